// ===== mcd_defs.svh
`ifndef MCD_DEFS_SVH
`define MCD_DEFS_SVH

// ************************************************************
// apb register map (byte addresses)
// ************************************************************
`define MCD_OFF_SETUP 8'h00
`define MCD_OFF_VCEIL 8'h04
`define MCD_OFF_VFLOOR 8'h08
`define MCD_OFF_STATUS 8'h0c
`define MCD_OFF_SNAP 8'h10

// field positions
`define MCD_SETUP_HALT_BIT 0
`define MCD_ST_BUSY_N_BIT 0
`define MCD_ST_BAD_BIT 1
`define MCD_ST_SCK_BIT 2
`define MCD_ST_SEEK_BIT 3
`define MCD_ST_DIR_BIT 4

// reset values
`define MCD_SETUP_RST 16'h0001
`define MCD_VCEIL_RST 20'hfffff
`define MCD_VFLOOR_RST 20'h00000

// ************************************************************
// command opcodes and masks
// ************************************************************
`define MCD_OP_READBACK 3'h1
`define MCD_OP_RUN 8'h50
`define MCD_OP_STEPCLK 8'h58
`define MCD_OP_MOVE 8'h40
`define MCD_OP_ABSOLUTE_SEEK_CMD 8'h60
`define MCD_OP_ABSOLUTE_SEEK_FORCED_SENSE_CMD 8'h68
`define MCD_OP_SEEK 8'h82
`define MCD_MASK_DIR 8'hfe
`define MCD_MASK_SEEK 8'hf6

// readback selector addresses and response lengths in bytes
`define MCD_SEL_ABSPOS 5'h01
`define MCD_SEL_SNAP 5'h03
`define MCD_SEL_VCEIL 5'h07
`define MCD_SEL_VFLOOR 5'h08
`define MCD_SEL_SETUP 5'h18
`define MCD_LEN_POS 2'd3
`define MCD_LEN_VEL 2'd3
`define MCD_LEN_SETUP 2'd2

// argument bytes of every motion command
`define MCD_ARG_BYTES 2'd3

`endif

// ===== mcd_pkg.sv
package mcd_pkg;

  // decoder sequencing
  typedef enum logic [1:0] {
    MCD_ST_IDLE = 2'b01,
    MCD_ST_ARG = 2'b10
  } mcd_state_t;

  // order handed to the motion engine
  typedef enum logic [2:0] {
    MCD_K_RUN = 3'h0,
    MCD_K_MOVE = 3'h1,
    MCD_K_ABSOLUTE_SEEK_CMD = 3'h2,
    MCD_K_ABSOLUTE_SEEK_FORCED_SENSE_CMD = 3'h3,
    MCD_K_SEEK = 3'h4,
    MCD_K_STEPCLK = 3'h5,
    MCD_K_HALT_SOFT = 3'h6,
    MCD_K_HALT_HARD = 3'h7
  } mcd_kind_t;

  typedef struct packed {
    logic valid;
    mcd_kind_t kind;
    logic dir;
    logic act;
    logic [21:0] arg;
  } mcd_motion_t;

endpackage

// ===== mcd_decoder.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "mcd_defs.svh"

// Summary of operation
// - readback returns selected register MSB first, byte count per register length.
// - readback value is captured at decode; later changes do not alter it.
// - readback of any existing register is accepted in every state.
// - readback of unknown selector is ignored and raises the error flag.
// - constant speed run starts at given speed; bit one forward, zero reverse.
// - run speed clamped between velocity ceiling and velocity floor.
// - run accepted anytime; busy low until target speed reached.
// - step-clock command enters mode, sets direction, raises flag, motor counts stopped.
// - run, positioning or motion command leaves step-clock; repeat only updates direction.
// - bridge protection events never leave step-clock mode.
// - step-clock never drives busy low; rejected with error while motor runs.
// - relative travel moves given count in selected sense and step unit.
// - relative travel holds busy low until done; rejected with error while running.
// - absolute seek takes shortest path to target; busy low until reached.
// - absolute seek while busy is low is ignored and raises the error flag.
// - forced-sense seek reaches target turning only in commanded direction.
// - forced-sense seek only after previous motion completes, else error.
// - switch seek runs until switch closes, clears or snapshots position, then halts.
// - switch seek speed clamped between velocity ceiling and floor.
// - with halt style bit low the switch event halts immediately.
// - switch seek accepted anytime; busy low until switch seen and motor stopped.
// - any byte that is no valid command is ignored and raises the error flag.
// - a new readback aborts a running response and loads the new value.
// - every other received byte answers with an all-zero byte.
module mcd_decoder #(
  parameter int VEL_W = 20,
  parameter int POS_W = 22
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // byte stream from and to the serial front end
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic [7:0] tx_byte,
  // motion engine
  input wire logic motor_running_in,
  input wire logic motion_done_in,
  input wire logic bridges_floating_in,
  input wire logic [POS_W-1:0] absolute_location_reg_in,
  output mcd_pkg::mcd_motion_t motion_cmd,
  output logic pos_clear,
  // switch pin, high while closed
  input wire logic switch_pin,
  // status
  output logic busy_n,
  output logic bad_instruction_flag,
  output logic external_stepping_flag
);

  // ************************************************************
  // state
  // ************************************************************
  mcd_pkg::mcd_state_t state_r, state_nxt;
  logic [15:0] setup_r;
  logic [VEL_W-1:0] vceil_r, vfloor_r;
  logic [POS_W-1:0] snap_r;
  logic busy_n_r, bad_r, sck_r, seeking_r, dir_r, act_r;
  logic [1:0] arg_cnt_r;
  logic [23:0] argbuf_r;
  mcd_pkg::mcd_kind_t pend_kind_r;
  logic pend_ok_r;
  logic [23:0] resp_r;
  logic [1:0] resp_cnt_r;
  logic [7:0] tx_r;
  mcd_pkg::mcd_motion_t mcmd_r;
  logic pos_clear_r;
  logic sw_meta_r, sw_sync_r, sw_prev_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;

  // ************************************************************
  // opcode decode
  // ************************************************************
  wire idle = (state_r == mcd_pkg::MCD_ST_IDLE);
  wire take = rx_valid & idle;
  wire [7:0] rb = rx_byte;
  wire [4:0] sel = rb[4:0];
  wire is_rb = (rb[7:5] == `MCD_OP_READBACK);
  wire is_run = ((rb & `MCD_MASK_DIR) == `MCD_OP_RUN);
  wire is_sck = ((rb & `MCD_MASK_DIR) == `MCD_OP_STEPCLK);
  wire is_move = ((rb & `MCD_MASK_DIR) == `MCD_OP_MOVE);
  wire is_absolute_seek_cmd = (rb == `MCD_OP_ABSOLUTE_SEEK_CMD);
  wire is_gdir = ((rb & `MCD_MASK_DIR) == `MCD_OP_ABSOLUTE_SEEK_FORCED_SENSE_CMD);
  wire is_seek = ((rb & `MCD_MASK_SEEK) == `MCD_OP_SEEK);
  // codes served by neighbouring blocks pass silently; a hazard if that list drifts
  wire is_other = (rb[7:5] == 3'h0) || ((rb & `MCD_MASK_SEEK) == 8'h92) ||
                  (rb == 8'h70) || (rb == 8'h78) || (rb == 8'hd8) || (rb == 8'hc0) ||
                  (rb == 8'hb0) || (rb == 8'hb8) || (rb == 8'ha0) || (rb == 8'ha8) ||
                  (rb == 8'hd0);
  wire is_motion = is_run | is_move | is_absolute_seek_cmd | is_gdir | is_seek;
  wire is_known = is_rb | is_sck | is_motion | is_other;

  // selector lookup; value sampled right at decode
  wire sel_ok = (sel == `MCD_SEL_ABSPOS) || (sel == `MCD_SEL_SNAP) ||
                (sel == `MCD_SEL_VCEIL) || (sel == `MCD_SEL_VFLOOR) ||
                (sel == `MCD_SEL_SETUP);
  wire [1:0] sel_len = (sel == `MCD_SEL_SETUP) ? `MCD_LEN_SETUP :
                       ((sel == `MCD_SEL_VCEIL) || (sel == `MCD_SEL_VFLOOR)) ?
                       `MCD_LEN_VEL : `MCD_LEN_POS;
  wire [23:0] sel_val = (sel == `MCD_SEL_ABSPOS) ? 24'(absolute_location_reg_in) :
                        (sel == `MCD_SEL_SNAP) ? 24'(snap_r) :
                        (sel == `MCD_SEL_VCEIL) ? 24'(vceil_r) :
                        (sel == `MCD_SEL_VFLOOR) ? 24'(vfloor_r) : 24'(setup_r);
  // left-justify so the most significant response byte leaves first
  wire [23:0] sel_just = (sel_len == 2'd3) ? sel_val :
                         (sel_len == 2'd2) ? {sel_val[15:0], 8'h00} :
                         {sel_val[7:0], 16'h0000};

  // acceptance from state at the opcode byte; step-clock counts as stopped
  wire running_eff = motor_running_in & ~sck_r;
  wire rb_load = take & is_rb & sel_ok;
  wire sck_ok = ~running_eff;
  wire move_ok = ~running_eff;
  wire absolute_seek_cmd_ok = busy_n_r;
  wire motion_ok = is_run | is_seek | (is_move & move_ok) |
                   ((is_absolute_seek_cmd | is_gdir) & absolute_seek_cmd_ok);
  wire cmd_err = take & (~is_known | (is_rb & ~sel_ok) | (is_sck & ~sck_ok) |
                 (is_motion & ~motion_ok));
  wire sck_take = take & is_sck & sck_ok;
  wire last_arg = rx_valid & ~idle & (arg_cnt_r == 2'd1);
  wire [23:0] arg_full = {argbuf_r[15:0], rx_byte};
  wire issue = last_arg & pend_ok_r;

  // ************************************************************
  // speed clamp and motion order build
  // ************************************************************
  // upper bits of the first argument byte are dropped here
  wire [VEL_W-1:0] spd_raw = arg_full[VEL_W-1:0];
  wire [VEL_W-1:0] spd_clamped = (spd_raw > vceil_r) ? vceil_r :
                                 (spd_raw < vfloor_r) ? vfloor_r : spd_raw;
  wire is_speed_kind = (pend_kind_r == mcd_pkg::MCD_K_RUN) ||
                       (pend_kind_r == mcd_pkg::MCD_K_SEEK);
  wire [POS_W-1:0] arg_sel = is_speed_kind ? POS_W'(spd_clamped) :
                             arg_full[POS_W-1:0];
  wire sw_rise = sw_sync_r & ~sw_prev_r;
  wire sw_hit = sw_rise & seeking_r & ~issue;
  wire halt_soft = setup_r[`MCD_SETUP_HALT_BIT];

  mcd_pkg::mcd_kind_t op_kind;
  always_comb begin
    if (is_run) begin
      op_kind = mcd_pkg::MCD_K_RUN;
    end else if (is_move) begin
      op_kind = mcd_pkg::MCD_K_MOVE;
    end else if (is_absolute_seek_cmd) begin
      op_kind = mcd_pkg::MCD_K_ABSOLUTE_SEEK_CMD;
    end else if (is_gdir) begin
      op_kind = mcd_pkg::MCD_K_ABSOLUTE_SEEK_FORCED_SENSE_CMD;
    end else begin
      op_kind = mcd_pkg::MCD_K_SEEK;
    end
  end

  // ************************************************************
  // sequencer: opcode then three argument bytes
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mcd_pkg::MCD_ST_IDLE: begin
        // rejected orders still swallow their arguments to keep framing
        if (take & is_motion) begin
          state_nxt = mcd_pkg::MCD_ST_ARG;
        end
      end
      mcd_pkg::MCD_ST_ARG: begin
        if (last_arg) begin
          state_nxt = mcd_pkg::MCD_ST_IDLE;
        end
      end
      default: state_nxt = mcd_pkg::MCD_ST_IDLE;
    endcase
  end

  // opcode latch and argument shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= mcd_pkg::MCD_ST_IDLE;
      arg_cnt_r <= 2'd0;
      argbuf_r <= 24'h000000;
      pend_kind_r <= mcd_pkg::MCD_K_RUN;
      pend_ok_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take & is_motion) begin
        arg_cnt_r <= `MCD_ARG_BYTES;
        pend_kind_r <= op_kind;
        pend_ok_r <= motion_ok;
        act_r <= rb[3];
      end else if (rx_valid & ~idle) begin
        arg_cnt_r <= arg_cnt_r - 2'd1;
        argbuf_r <= {argbuf_r[15:0], rx_byte};
      end
    end
  end

  // orders to the motion engine, one-cycle valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcmd_r <= '0;
      pos_clear_r <= 1'b0;
      snap_r <= '0;
    end else begin
      mcmd_r.valid <= issue | sck_take | sw_hit;
      pos_clear_r <= sw_hit & ~act_r;
      if (sw_hit & act_r) begin
        snap_r <= absolute_location_reg_in;
      end
      if (sck_take) begin
        mcmd_r.kind <= mcd_pkg::MCD_K_STEPCLK;
        mcmd_r.dir <= rb[0];
        mcmd_r.arg <= '0;
      end else if (issue) begin
        mcmd_r.kind <= pend_kind_r;
        mcmd_r.dir <= dir_r;
        mcmd_r.act <= act_r;
        mcmd_r.arg <= arg_sel;
      end else if (sw_hit) begin
        mcmd_r.kind <= halt_soft ? mcd_pkg::MCD_K_HALT_SOFT :
                       mcd_pkg::MCD_K_HALT_HARD;
      end
    end
  end

  // busy, step-clock, seek tracking and error flag
  // set beats clear on the error flag so no event slips past software
  wire bad_clr = pready_r & psel & penable & pwrite & (paddr == `MCD_OFF_STATUS) &
                 pwdata[`MCD_ST_BAD_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_n_r <= 1'b1;
      sck_r <= 1'b0;
      seeking_r <= 1'b0;
      dir_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      bad_r <= cmd_err | (bad_r & ~bad_clr);
      if (take & is_motion) begin
        dir_r <= rb[0];
      end else if (sck_take) begin
        dir_r <= rb[0];
      end
      if (issue) begin
        busy_n_r <= 1'b0;
        sck_r <= 1'b0;
      end else begin
        if (motion_done_in & ~seeking_r) begin
          busy_n_r <= 1'b1;
        end
        // bridges_floating_in deliberately has no say here
        if (sck_take) begin
          sck_r <= 1'b1;
        end
      end
      if (issue) begin
        seeking_r <= (pend_kind_r == mcd_pkg::MCD_K_SEEK);
      end else if (sw_hit) begin
        seeking_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // response shifter
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_r <= 24'h000000;
      resp_cnt_r <= 2'd0;
      tx_r <= 8'h00;
    end else if (rx_valid) begin
      if (rb_load) begin
        tx_r <= sel_just[23:16];
        resp_r <= {sel_just[15:0], 8'h00};
        resp_cnt_r <= sel_len - 2'd1;
      end else if (resp_cnt_r != 2'd0) begin
        tx_r <= resp_r[23:16];
        resp_r <= {resp_r[15:0], 8'h00};
        resp_cnt_r <= resp_cnt_r - 2'd1;
      end else begin
        tx_r <= 8'h00;
      end
    end
  end

  // ************************************************************
  // switch pin synchroniser
  // ************************************************************
  // only sw_sync_r and later feed the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_r <= 1'b0;
      sw_sync_r <= 1'b0;
      sw_prev_r <= 1'b0;
    end else begin
      sw_meta_r <= switch_pin;
      sw_sync_r <= sw_meta_r;
      sw_prev_r <= sw_sync_r;
    end
  end

  // ************************************************************
  // apb slave, one wait state so read data leaves a flop
  // ************************************************************
  wire acc = psel & penable;
  wire wr_en = acc & pready_r & pwrite;
  wire addr_ok = (paddr == `MCD_OFF_SETUP) || (paddr == `MCD_OFF_VCEIL) ||
                 (paddr == `MCD_OFF_VFLOOR) || (paddr == `MCD_OFF_STATUS) ||
                 (paddr == `MCD_OFF_SNAP);
  wire [31:0] status_w = {27'h0000000, dir_r, seeking_r, sck_r, bad_r, busy_n_r};
  wire [31:0] rd_mux = (paddr == `MCD_OFF_SETUP) ? {16'h0000, setup_r} :
                       (paddr == `MCD_OFF_VCEIL) ? 32'(vceil_r) :
                       (paddr == `MCD_OFF_VFLOOR) ? 32'(vfloor_r) :
                       (paddr == `MCD_OFF_STATUS) ? status_w :
                       (paddr == `MCD_OFF_SNAP) ? 32'(snap_r) : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~addr_ok;
      prdata_r <= (acc & ~pready_r & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // configuration writes, taken only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_r <= `MCD_SETUP_RST;
      vceil_r <= `MCD_VCEIL_RST;
      vfloor_r <= `MCD_VFLOOR_RST;
    end else if (wr_en) begin
      if (paddr == `MCD_OFF_SETUP) begin
        setup_r <= pwdata[15:0];
      end
      if (paddr == `MCD_OFF_VCEIL) begin
        vceil_r <= pwdata[VEL_W-1:0];
      end
      if (paddr == `MCD_OFF_VFLOOR) begin
        vfloor_r <= pwdata[VEL_W-1:0];
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_byte = tx_r;
  assign motion_cmd = mcmd_r;
  assign pos_clear = pos_clear_r;
  assign busy_n = busy_n_r;
  assign bad_instruction_flag = bad_r;
  assign external_stepping_flag = sck_r;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_rb_first;
    @(posedge pclk) disable iff (!presetn)
      rb_load |=> (tx_r == $past(sel_just[23:16])) && (resp_cnt_r == $past(sel_len) - 2'd1);
  endproperty
  a_rb_first: assert property (p_rb_first) else $error("readback first byte wrong");

  property p_rb_frozen;
    @(posedge pclk) disable iff (!presetn)
      (resp_cnt_r != 2'd0) && !rx_valid |=> $stable(resp_r) && $stable(tx_r);
  endproperty
  a_rb_frozen: assert property (p_rb_frozen) else $error("response byte changed");

  property p_zero_resp;
    @(posedge pclk) disable iff (!presetn)
      rx_valid && !rb_load && (resp_cnt_r == 2'd0) |=> tx_r == 8'h00;
  endproperty
  a_zero_resp: assert property (p_zero_resp) else $error("nonzero idle response");

  property p_err_flag;
    @(posedge pclk) disable iff (!presetn)
      cmd_err |=> bad_r;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not raised");

  property p_move_running;
    @(posedge pclk) disable iff (!presetn)
      take && is_move && running_eff |=> !pend_ok_r ##0 bad_r;
  endproperty
  a_move_running: assert property (p_move_running) else $error("move accepted while running");

  property p_absolute_seek_cmd_busy;
    @(posedge pclk) disable iff (!presetn)
      take && (is_absolute_seek_cmd || is_gdir) && !busy_n_r |=> !pend_ok_r && bad_r;
  endproperty
  a_absolute_seek_cmd_busy: assert property (p_absolute_seek_cmd_busy) else $error("seek accepted while busy");

  property p_sck_enter;
    @(posedge pclk) disable iff (!presetn)
      sck_take && !issue |=> sck_r && (busy_n_r == $past(busy_n_r) || $past(motion_done_in));
  endproperty
  a_sck_enter: assert property (p_sck_enter) else $error("step-clock entry wrong");

  property p_sck_hold;
    @(posedge pclk) disable iff (!presetn)
      sck_r && bridges_floating_in && !issue |=> sck_r;
  endproperty
  a_sck_hold: assert property (p_sck_hold) else $error("step-clock left on fault");

  property p_clamp;
    @(posedge pclk) disable iff (!presetn)
      mcmd_r.valid && (mcmd_r.kind == mcd_pkg::MCD_K_RUN) && (vfloor_r <= vceil_r) |->
        (mcmd_r.arg <= POS_W'(vceil_r)) && (mcmd_r.arg >= POS_W'(vfloor_r));
  endproperty
  a_clamp: assert property (p_clamp) else $error("run speed not clamped");

  property p_hard_halt;
    @(posedge pclk) disable iff (!presetn)
      sw_hit && !halt_soft |=> mcmd_r.valid && (mcmd_r.kind == mcd_pkg::MCD_K_HALT_HARD);
  endproperty
  a_hard_halt: assert property (p_hard_halt) else $error("switch halt style wrong");

endmodule

// ===== mcd_host.sv
`timescale 1ns/10ps

// ****
// host side of the byte stream
// ****
module mcd_host (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the bench
  input wire logic send,
  input wire logic [7:0] send_byte,
  // byte stream into the decoder
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  // one pulse per byte; idle data toggles so a stale byte never reads as fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_valid <= send;
      rx_byte <= send ? send_byte : ~rx_byte;
    end
  end
endmodule

// ===== motion_command_decoder_test.sv
`timescale 1ns/10ps
`include "mcd_defs.svh"

// ****
// bench
// ****
module motion_command_decoder_test;
  logic pclk, presetn, psel, penable, pwrite, send, running, done, floating, sw, rx_valid;
  logic pready, pslverr, busy_n, bad, sck, pos_clear, err;
  logic [7:0] paddr, sbyte, tx_byte, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [21:0] pos, p;
  logic [19:0] ceil_v, floor_v, target_velocity_arg;
  logic [7:0] rej [3] = '{8'h41, 8'h60, 8'h69};
  logic [7:0] ok [3] = '{8'h40, 8'h60, 8'h69};
  mcd_pkg::mcd_motion_t motion_cmd, got;
  int fail_count, comparisons, cyc, ncmd, nclr, i, n;

  mcd_host host (.pclk(pclk), .presetn(presetn), .send(send), .send_byte(sbyte),
    .rx_valid(rx_valid), .rx_byte(rx_byte));
  mcd_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_byte(tx_byte),
    .motor_running_in(running), .motion_done_in(done), .bridges_floating_in(floating),
    .absolute_location_reg_in(pos), .motion_cmd(motion_cmd), .pos_clear(pos_clear), .switch_pin(sw),
    .busy_n(busy_n), .bad_instruction_flag(bad), .external_stepping_flag(sck));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // latch each order, count clears; the cycle ceiling cuts a hang short
  always @(posedge pclk) begin
    if (motion_cmd.valid === 1'b1) begin
      got <= motion_cmd;
      ncmd <= ncmd + 1;
    end
    if (pos_clear === 1'b1) nclr <= nclr + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // returns just after the decoder took the byte
  task automatic sb(input logic [7:0] b);
    @(posedge pclk);
    send <= 1'b1;
    sbyte <= b;
    @(posedge pclk);
    send <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [21:0] a);
    sb(op);
    sb({2'($urandom), a[21:16]});
    sb(a[15:8]);
    sb(a[7:0]);
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic bad_seen(input int c);
    @(posedge pclk);
    #1;
    chk("order count", c, ncmd);
    chk("error flag", 1, bad);
    apb(1'b1, `MCD_OFF_STATUS, 32'h2);
  endtask

  task automatic pulse_done();
    @(posedge pclk);
    done <= 1'b1;
    @(posedge pclk);
    done <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  function automatic logic [21:0] clampv(input logic [19:0] s);
    if (s > ceil_v) return {2'b00, ceil_v};
    if (s < floor_v) return {2'b00, floor_v};
    return {2'b00, s};
  endfunction

  // ****
  // main sequence
  // ****
  initial begin
    {presetn, psel, penable, pwrite, send, running, done, floating, sw} = '0;
    {paddr, pwdata, sbyte, pos} = '0;
    void'($urandom(64177));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    ceil_v = 20'h40000 + 20'($urandom_range(999));
    floor_v = 20'h00100 + 20'($urandom_range(99));
    apb(1'b1, `MCD_OFF_VCEIL, {12'h0, ceil_v});
    apb(1'b1, `MCD_OFF_VFLOOR, {12'h0, floor_v});
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 1, err);
    // step-clock entry, bridge fault, direction update, then leaving
    sb(8'h59);
    @(posedge pclk);
    floating <= 1'b1;
    repeat (5) @(posedge pclk);
    #1;
    chk("stepclk", {mcd_pkg::MCD_K_STEPCLK, 1'b1}, {got.kind, got.dir});
    chk("stepclk flags", 2'b11, {sck, busy_n});
    sb(8'h58);
    repeat (2) @(posedge pclk);
    #1;
    chk("stepclk dir", {1'b0, 1'b1}, {got.dir, sck});
    for (i = 0; i < 3; i++) begin
      p = 22'($urandom);
      cmd(ok[i], p);
      chk("order", {3'(i + 1), p}, {got.kind, got.arg});
      chk("order flags", 2'b00, {sck, busy_n});
      pulse_done();
    end
    // seek to switch, soft then hard halt
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `MCD_OFF_SETUP, 32'(1 - i));
      n = nclr;
      pos <= 22'($urandom);
      target_velocity_arg = 20'($urandom);
      p = clampv(target_velocity_arg);
      cmd(i ? 8'h8b : 8'h82, {2'b00, target_velocity_arg});
      chk("seek", {mcd_pkg::MCD_K_SEEK, i[0], p}, {got.kind, got.act, got.arg});
      @(posedge pclk);
      sw <= 1'b1;
      repeat (8) @(posedge pclk);
      #1;
      chk("halt", i ? mcd_pkg::MCD_K_HALT_HARD : mcd_pkg::MCD_K_HALT_SOFT, got.kind);
      chk("clears", n + 1 - i, nclr);
      chk("seek busy", 0, busy_n);
      @(posedge pclk);
      sw <= 1'b0;
      pulse_done();
    end
    apb(1'b0, `MCD_OFF_SNAP, 32'h0);
    chk("snapshot", {10'h0, pos}, rd);
    // runs above, below and inside the limits
    for (i = 0; i < 3; i++) begin
      target_velocity_arg = i == 0 ? 20'hfffff : i == 1 ? 20'h00001 : floor_v + 20'($urandom_range(999));
      cmd(8'h50 | 8'(i & 1), {2'($urandom), target_velocity_arg});
      p = clampv(target_velocity_arg);
      chk("run", {mcd_pkg::MCD_K_RUN, i[0], p}, {got.kind, got.dir, got.arg});
      chk("run busy", 0, busy_n);
    end
    @(posedge pclk);
    running <= 1'b1;
    for (i = 0; i < 3; i++) begin
      n = ncmd;
      cmd(rej[i], 22'($urandom));
      bad_seen(n);
    end
    foreach (ok[i]) begin
      n = ncmd;
      sb(i == 0 ? 8'h59 : i == 1 ? 8'h3f : 8'he5);
      bad_seen(n);
    end
    // readback while busy, value frozen at decode
    p = 22'($urandom);
    pos <= p;
    sb(8'h21);
    @(posedge pclk);
    pos <= ~p;
    for (i = 2; i >= 0; i--) begin
      chk("readback", 8'({2'b00, p} >> (8 * i)), tx_byte);
      sb(8'h00);
    end
    chk("zero fill", 0, tx_byte);
    sb(8'h21);
    sb(8'h27);
    chk("abort", {4'h0, ceil_v[19:16]}, tx_byte);
    test_done();
  end
endmodule
